//--- rtl/iicm_master.sv
// i2c master sequencer with multi-master arbitration and collision detect
//
// Overview of operation
// - released one bit read low: collision, idle
// - byte collision: halt, clear full, release, rewritable
// - sequence collision: abort, release, clear enable
// - keep monitoring; stop on bus sets interrupt
// - new buffer write restarts at first bit
// - bus free: stop seen, or neither seen
// - start with line low: abort, collision, idle
// - start: count reload with sda high; scl low collides
// - sda low during count: assert sda early
// - sda low phase: scl low ignored; then scl low
// - repeated start: count, release scl, sda low collides
// - repeated start: early sda fall is no collision
// - scl falls before sda driven: collision
// - expiry: sda low, recount, then scl low
// - stop: sda low, release scl, count, sda check
// - stop: scl low before sda release collides
`timescale 1ns/1ps
`default_nettype none

module iicm_master (
	input  wire logic                       core_clk,        // 25 MHz core clock
	input  wire logic                       nrst,            // async reset, active low
	input  wire logic [iicm_pkg::ADDR_W-1:0] avs_address,    // byte address
	input  wire logic                       avs_read,        // read request
	input  wire logic                       avs_write,       // write request
	input  wire logic [iicm_pkg::DATA_W-1:0] avs_writedata,  // write data
	output var  logic [iicm_pkg::DATA_W-1:0] avs_readdata,   // read data
	output logic                            avs_waitrequest, // stall
	output logic                            irq,             // level interrupt
	input  wire logic                       scl_in,          // clock pin level
	output logic                            scl_out,         // clock pin drive value
	output var  logic                       scl_oe_n,        // low pulls clock low
	input  wire logic                       sda_in,          // data pin level
	output logic                            sda_out,         // data pin drive value
	output var  logic                       sda_oe_n         // low pulls data low
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	iicm_pkg::iicm_state_type      state;        // sequencer state
	logic [1:0]                    pins_s;       // synchronised {scl, sda}
	logic                          scl_s;        // clock level
	logic                          sda_s;        // data level
	logic                          scl_p;        // clock level last cycle
	logic                          sda_p;        // data level last cycle
	logic [iicm_pkg::BAUD_W-1:0]   cnt;          // baud_reload_counter
	logic [iicm_pkg::BAUD_W-1:0]   baud;         // baud_reload_value
	logic                          hi_run;       // count phase running
	logic [3:0]                    bit_cnt;      // bit index, 8 is ack
	logic [7:0]                    shreg;        // transmit shifter
	logic [7:0]                    tx_data;      // transfer_buffer
	logic                          tx_go;        // buffer write accepted
	logic                          buf_full;     // buffer_full_flag
	logic [iicm_pkg::CTL_W-1:0]    ctl;          // sequence_control_register
	logic                          start_seen;   // start seen on bus
	logic                          stop_seen;    // stop seen on bus
	logic                          stop_det;     // stop seen this cycle
	logic                          ack_bit;      // last acknowledge level
	logic                          bcl_ev;       // collision pulse
	logic                          done_ev;      // sequence finished pulse
	logic                          byte_ev;      // eight bits shifted pulse
	logic                          ack_ev;       // ack slot finished pulse
	logic                          collide;      // collision this cycle
	logic                          cmd_ok;       // idle and nothing pending
	logic                          cnt_zero;     // count expired
	logic                          bus_free;     // bus may be taken
	logic [iicm_pkg::IRQ_W-1:0]    irq_stat;     // sticky events
	logic [iicm_pkg::IRQ_W-1:0]    irq_mask;     // event mask
	logic                          resp;         // answer cycle of bus access
	logic                          wr_do;        // write takes effect
	logic                          rd_do;        // read completes

	// ----------------------------------------------------------------
	// pins
	// ----------------------------------------------------------------
	// open drain: drive value is always low, enable decides
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;

	// both pins pass two flops before use
	iicm_sync #(
		.WIDTH (2)
	) u_sync (
		.core_clk (core_clk),
		.nrst     (nrst),
		.din      ({scl_in, sda_in}),
		.dout     (pins_s)
	);
	assign scl_s    = pins_s[1];
	assign sda_s    = pins_s[0];
	assign cnt_zero = (cnt == '0);
	assign cmd_ok   = (state == iicm_pkg::S_IDLE) && !(bcl_ev || done_ev || ack_ev);

	// ----------------------------------------------------------------
	// collision detection
	// ----------------------------------------------------------------
	// each checked state names the line levels that mean another master won; the others never collide
	always_comb begin
		collide = 1'b0;
		unique case (state)
			iicm_pkg::S_IDLE:
				// a start begun with either line low
				collide = cmd_ok && !tx_go && ctl[iicm_pkg::CTL_START]
				          && (!sda_s || !scl_s);
			iicm_pkg::S_ST_REL:
				collide = !scl_s && sda_s;
			iicm_pkg::S_TX_HI:
				// released a one but the line reads low
				collide = hi_run && (bit_cnt != iicm_pkg::ACK_SLOT) && shreg[7]
				          && !sda_s;
			iicm_pkg::S_RS_SCL:
				collide = scl_s && !sda_s;
			iicm_pkg::S_RS_HI:
				collide = !scl_s && !cnt_zero;
			iicm_pkg::S_SP_HI:
				collide = !scl_s;
			iicm_pkg::S_SP_END:
				collide = cnt_zero && !sda_s;
			iicm_pkg::S_AK_HI:
				collide = hi_run && ctl[iicm_pkg::CTL_ACKDT] && !sda_s;
			default:
				collide = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	// one state machine for start, repeated start, stop, ack and bytes
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state    <= iicm_pkg::S_IDLE;
			cnt      <= '0;
			hi_run   <= 1'b0;
			bit_cnt  <= 4'h0;
			shreg    <= 8'h00;
			scl_oe_n <= 1'b1;
			sda_oe_n <= 1'b1;
			ack_bit  <= 1'b1;
			bcl_ev   <= 1'b0;
			done_ev  <= 1'b0;
			byte_ev  <= 1'b0;
			ack_ev   <= 1'b0;
		end else begin
			bcl_ev  <= 1'b0;
			done_ev <= 1'b0;
			byte_ev <= 1'b0;
			ack_ev  <= 1'b0;
			// countdown that stops at zero, loads below take precedence
			if (!cnt_zero) begin
				cnt <= cnt - 1'b1;
			end
			if (collide) begin
				// abort, let go of both lines, back to idle
				scl_oe_n <= 1'b1;
				sda_oe_n <= 1'b1;
				hi_run   <= 1'b0;
				bcl_ev   <= 1'b1;
				state    <= iicm_pkg::S_IDLE;
			end else begin
				unique case (state)
					iicm_pkg::S_IDLE: begin
						hi_run <= 1'b0;
						if (cmd_ok) begin
							if (tx_go) begin
								// always from the first data bit
								shreg    <= tx_data;
								bit_cnt  <= 4'h0;
								scl_oe_n <= 1'b0;
								cnt      <= baud;
								state    <= iicm_pkg::S_TX_LO;
							end else if (ctl[iicm_pkg::CTL_START]) begin
								// lines released and high, count with sda high
								scl_oe_n <= 1'b1;
								sda_oe_n <= 1'b1;
								cnt      <= baud;
								state    <= iicm_pkg::S_ST_REL;
							end else if (ctl[iicm_pkg::CTL_RSTART]) begin
								scl_oe_n <= 1'b0;
								sda_oe_n <= 1'b1;
								state    <= iicm_pkg::S_RS_REL;
							end else if (ctl[iicm_pkg::CTL_STOP]) begin
								scl_oe_n <= 1'b0;
								sda_oe_n <= 1'b0;
								state    <= iicm_pkg::S_SP_SDA;
							end else if (ctl[iicm_pkg::CTL_ACK]) begin
								scl_oe_n <= 1'b0;
								sda_oe_n <= ctl[iicm_pkg::CTL_ACKDT];
								cnt      <= baud;
								state    <= iicm_pkg::S_AK_LO;
							end
						end
					end
					iicm_pkg::S_ST_REL: begin
						if (!sda_s) begin
							// someone else started: restart count, assert early
							sda_oe_n <= 1'b0;
							cnt      <= baud;
							state    <= iicm_pkg::S_ST_LOW;
						end else if (cnt_zero) begin
							sda_oe_n <= 1'b0;
							cnt      <= baud;
							state    <= iicm_pkg::S_ST_LOW;
						end
					end
					iicm_pkg::S_ST_LOW: begin
						// clock level is not checked here
						if (cnt_zero) begin
							scl_oe_n <= 1'b0;
							done_ev  <= 1'b1;
							state    <= iicm_pkg::S_IDLE;
						end
					end
					iicm_pkg::S_TX_LO: begin
						// data changes while the clock is low, ack slot released
						sda_oe_n <= (bit_cnt == iicm_pkg::ACK_SLOT) || shreg[7];
						if (cnt_zero) begin
							scl_oe_n <= 1'b1;
							hi_run   <= 1'b0;
							state    <= iicm_pkg::S_TX_HI;
						end
					end
					iicm_pkg::S_TX_HI: begin
						if (!hi_run) begin
							// clock stretching: count only once the clock is high
							if (scl_s) begin
								hi_run <= 1'b1;
								cnt    <= baud;
							end
						end else if (cnt_zero) begin
							scl_oe_n <= 1'b0;
							hi_run   <= 1'b0;
							cnt      <= baud;
							if (bit_cnt == iicm_pkg::ACK_SLOT) begin
								ack_bit  <= sda_s;
								ack_ev   <= 1'b1;
								sda_oe_n <= 1'b1;
								state    <= iicm_pkg::S_IDLE;
							end else begin
								shreg   <= {shreg[6:0], 1'b0};
								bit_cnt <= bit_cnt + 4'h1;
								byte_ev <= (bit_cnt == 4'h7);
								state   <= iicm_pkg::S_TX_LO;
							end
						end
					end
					iicm_pkg::S_RS_REL: begin
						// wait for released data to float high, then count
						if (sda_s) begin
							if (!hi_run) begin
								hi_run <= 1'b1;
								cnt    <= baud;
							end else if (cnt_zero) begin
								scl_oe_n <= 1'b1;
								hi_run   <= 1'b0;
								state    <= iicm_pkg::S_RS_SCL;
							end
						end
					end
					iicm_pkg::S_RS_SCL: begin
						if (scl_s) begin
							cnt   <= baud;
							state <= iicm_pkg::S_RS_HI;
						end
					end
					iicm_pkg::S_RS_HI: begin
						// a data fall here is another start, not a loss
						if (cnt_zero) begin
							sda_oe_n <= 1'b0;
							cnt      <= baud;
							state    <= iicm_pkg::S_RS_LOW;
						end
					end
					iicm_pkg::S_RS_LOW: begin
						if (cnt_zero) begin
							scl_oe_n <= 1'b0;
							done_ev  <= 1'b1;
							state    <= iicm_pkg::S_IDLE;
						end
					end
					iicm_pkg::S_SP_SDA: begin
						// data seen low, one count, then release the clock
						if (!sda_s) begin
							if (!hi_run) begin
								hi_run <= 1'b1;
								cnt    <= baud;
							end else if (cnt_zero) begin
								scl_oe_n <= 1'b1;
								hi_run   <= 1'b0;
								state    <= iicm_pkg::S_SP_REL;
							end
						end
					end
					iicm_pkg::S_SP_REL: begin
						if (scl_s) begin
							cnt   <= baud;
							state <= iicm_pkg::S_SP_HI;
						end
					end
					iicm_pkg::S_SP_HI: begin
						if (cnt_zero) begin
							sda_oe_n <= 1'b1;
							cnt      <= baud;
							state    <= iicm_pkg::S_SP_END;
						end
					end
					iicm_pkg::S_SP_END: begin
						if (cnt_zero) begin
							done_ev <= 1'b1;
							state   <= iicm_pkg::S_IDLE;
						end
					end
					iicm_pkg::S_AK_LO: begin
						if (cnt_zero) begin
							scl_oe_n <= 1'b1;
							hi_run   <= 1'b0;
							state    <= iicm_pkg::S_AK_HI;
						end
					end
					iicm_pkg::S_AK_HI: begin
						if (!hi_run) begin
							if (scl_s) begin
								hi_run <= 1'b1;
								cnt    <= baud;
							end
						end else if (cnt_zero) begin
							scl_oe_n <= 1'b0;
							sda_oe_n <= 1'b1;
							done_ev  <= 1'b1;
							state    <= iicm_pkg::S_IDLE;
						end
					end
					default: begin
						// illegal code: release and recover
						scl_oe_n <= 1'b1;
						sda_oe_n <= 1'b1;
						state    <= iicm_pkg::S_IDLE;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// bus monitor
	// ----------------------------------------------------------------
	// watches start and stop on the bus at all times, even after a loss
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			scl_p      <= 1'b1;
			sda_p      <= 1'b1;
			start_seen <= 1'b0;
			stop_seen  <= 1'b0;
			stop_det   <= 1'b0;
		end else begin
			scl_p    <= scl_s;
			sda_p    <= sda_s;
			stop_det <= 1'b0;
			if (scl_s && scl_p && sda_p && !sda_s) begin
				start_seen <= 1'b1;
				stop_seen  <= 1'b0;
			end else if (scl_s && scl_p && !sda_p && sda_s) begin
				start_seen <= 1'b0;
				stop_seen  <= 1'b1;
				stop_det   <= 1'b1;
			end
		end
	end

	assign bus_free = stop_seen || (!start_seen && !stop_seen);

	// ----------------------------------------------------------------
	// avalon slave: one wait cycle per access
	// ----------------------------------------------------------------
	assign avs_waitrequest = (avs_read || avs_write) && !resp;
	assign wr_do           = avs_write && resp;
	assign rd_do           = avs_read && resp;

	// answer flag and registered read data
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			resp         <= 1'b0;
			avs_readdata <= '0;
		end else begin
			resp <= (avs_read || avs_write) && !resp;
			if (avs_read && !resp) begin
				avs_readdata <= '0;
				unique case (avs_address)
					iicm_pkg::OFS_CTRL: avs_readdata[iicm_pkg::CTL_W-1:0] <= ctl;
					iicm_pkg::OFS_STAT: avs_readdata[iicm_pkg::STA_W-1:0] <=
						{ack_bit, state != iicm_pkg::S_IDLE, bus_free,
						 stop_seen, start_seen, buf_full};
					iicm_pkg::OFS_BUF:  avs_readdata[7:0] <= tx_data;
					iicm_pkg::OFS_BAUD: avs_readdata[iicm_pkg::BAUD_W-1:0] <= baud;
					iicm_pkg::OFS_IRQ:  avs_readdata[iicm_pkg::IRQ_W-1:0] <= irq_stat;
					iicm_pkg::OFS_MASK: avs_readdata[iicm_pkg::IRQ_W-1:0] <= irq_mask;
					default:            avs_readdata <= '0;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// control and baud registers
	// ----------------------------------------------------------------
	// sequence enables clear on completion or collision; a write wins
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ctl      <= '0;
			baud     <= iicm_pkg::BAUD_RST;
			irq_mask <= '0;
		end else begin
			if (done_ev || bcl_ev) begin
				ctl[iicm_pkg::CTL_ACK:iicm_pkg::CTL_START] <= 4'h0;
			end
			if (wr_do && avs_address == iicm_pkg::OFS_CTRL) begin
				ctl <= avs_writedata[iicm_pkg::CTL_W-1:0];
			end
			if (wr_do && avs_address == iicm_pkg::OFS_BAUD) begin
				baud <= avs_writedata[iicm_pkg::BAUD_W-1:0];
			end
			if (wr_do && avs_address == iicm_pkg::OFS_MASK) begin
				irq_mask <= avs_writedata[iicm_pkg::IRQ_W-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// transfer buffer
	// ----------------------------------------------------------------
	// accepted only while idle and empty; otherwise the write is dropped
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			tx_data  <= 8'h00;
			tx_go    <= 1'b0;
			buf_full <= 1'b0;
		end else begin
			tx_go <= 1'b0;
			if (byte_ev || bcl_ev) begin
				buf_full <= 1'b0;
			end
			if (wr_do && avs_address == iicm_pkg::OFS_BUF && cmd_ok && !buf_full) begin
				tx_data  <= avs_writedata[7:0];
				tx_go    <= 1'b1;
				buf_full <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------
	// sticky flags cleared by a read; a new event in that cycle survives
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			irq_stat <= '0;
		end else begin
			if (rd_do && avs_address == iicm_pkg::OFS_IRQ) begin
				irq_stat <= '0;
			end
			if (done_ev || ack_ev || stop_det) begin
				irq_stat[iicm_pkg::IRQ_PORT] <= 1'b1;
			end
			if (bcl_ev) begin
				irq_stat[iicm_pkg::IRQ_BCL] <= 1'b1;
			end
		end
	end

	assign irq = |(irq_stat & irq_mask);

endmodule : iicm_master

`default_nettype wire

//--- rtl/iicm_pkg.sv
// shared constants and types of the multi-master i2c collision block
package iicm_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam int          ADDR_W    = 5;          // avalon byte address width
	localparam int          DATA_W    = 32;         // avalon data width
	localparam logic [4:0]  OFS_CTRL  = 5'h00;      // sequence_control_register
	localparam logic [4:0]  OFS_STAT  = 5'h04;      // port_status_register
	localparam logic [4:0]  OFS_BUF   = 5'h08;      // transfer_buffer
	localparam logic [4:0]  OFS_BAUD  = 5'h0C;      // baud_reload_value
	localparam logic [4:0]  OFS_IRQ   = 5'h10;      // interrupt status, read clears
	localparam logic [4:0]  OFS_MASK  = 5'h14;      // interrupt mask

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CTL_START   = 0;                 // start sequence enable
	localparam int CTL_RSTART  = 1;                 // repeated start enable
	localparam int CTL_STOP    = 2;                 // stop sequence enable
	localparam int CTL_ACK     = 3;                 // acknowledge sequence enable
	localparam int CTL_ACKDT   = 4;                 // acknowledge data bit
	localparam int CTL_W       = 5;                 // control width
	localparam int STA_BUF     = 0;                 // buffer_full_flag
	localparam int STA_START   = 1;                 // start seen on bus
	localparam int STA_STOP    = 2;                 // stop seen on bus
	localparam int STA_FREE    = 3;                 // bus free
	localparam int STA_BUSY    = 4;                 // sequencer busy
	localparam int STA_ACKSTAT = 5;                 // acknowledge from slave
	localparam int STA_W       = 6;                 // status width
	localparam int IRQ_PORT    = 0;                 // port_interrupt_flag
	localparam int IRQ_BCL     = 1;                 // bus_collision_flag
	localparam int IRQ_W       = 2;                 // interrupt width

	// ----------------------------------------------------------------
	// reset values and counts
	// ----------------------------------------------------------------
	localparam int          BAUD_W    = 7;          // reload bits 6:0
	localparam logic [6:0]  BAUD_RST  = 7'h09;      // reload after reset
	localparam logic [3:0]  ACK_SLOT  = 4'h8;       // bit index of the ack clock

	// sequencer states, gray in the order listed
	typedef enum logic [3:0] {
		S_IDLE   = 4'h0,
		S_ST_REL = 4'h1,
		S_ST_LOW = 4'h3,
		S_TX_LO  = 4'h2,
		S_TX_HI  = 4'h6,
		S_RS_REL = 4'h7,
		S_RS_SCL = 4'h5,
		S_RS_HI  = 4'h4,
		S_RS_LOW = 4'hC,
		S_SP_SDA = 4'hD,
		S_SP_REL = 4'hF,
		S_SP_HI  = 4'hE,
		S_SP_END = 4'hA,
		S_AK_LO  = 4'hB,
		S_AK_HI  = 4'h9
	} iicm_state_type;

endpackage : iicm_pkg

//--- rtl/iicm_sync.sv
// two-flop synchroniser for the bus pins
`timescale 1ns/1ps
`default_nettype none

module iicm_sync #(
	parameter int WIDTH = 2                      // number of pins
) (
	input  wire logic             core_clk,      // core clock
	input  wire logic             nrst,          // async reset, active low
	input  wire logic [WIDTH-1:0] din,           // raw pin levels
	output var  logic [WIDTH-1:0] dout           // synchronised levels
);

	// ----------------------------------------------------------------
	// one pair of flops per pin
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic meta;                          // first stage, read by second only
			// pins idle high on an open-drain bus
			always_ff @(posedge core_clk or negedge nrst) begin
				if (!nrst) begin
					meta    <= 1'b1;
					dout[i] <= 1'b1;
				end else begin
					meta    <= din[i];
					dout[i] <= meta;
				end
			end
		end
	endgenerate

endmodule : iicm_sync

`default_nettype wire

//--- testbench/iicm_bus_peer.sv
// bus neighbour: an acking slave and a party that can hold a line low
`timescale 1ns/1ps
`default_nettype none
module iicm_bus_peer (
	input  wire logic core_clk,
	input  wire logic scl,
	input  wire logic sda,
	input  wire logic hold_scl,
	input  wire logic hold_sda,
	output logic      scl_oe_n,
	output logic      sda_oe_n
);
	logic scl_q;  // last clock level
	logic sda_q;  // last data level
	int   falls;  // clock falls since the last start
	always_ff @(posedge core_clk) begin
		scl_q <= scl;
		sda_q <= sda;
		if (scl && sda_q && !sda) falls <= 0;
		else if (scl_q && !scl) falls <= falls + 1;
	end
	// ack in the ninth clock; a released line goes to the pull-up
	assign sda_oe_n = !(hold_sda || (falls != 0 && falls % 9 == 0));
	assign scl_oe_n = !hold_scl;
endmodule : iicm_bus_peer
`default_nettype wire

//--- testbench/iicm_master_bench.sv
// bench for the i2c collision block
`timescale 1ns/1ps
`default_nettype none
module iicm_master_bench;
	localparam logic [4:0] r_ctl = iicm_pkg::OFS_CTRL, r_sta = iicm_pkg::OFS_STAT;
	localparam logic [4:0] r_irq = iicm_pkg::OFS_IRQ, r_buf = iicm_pkg::OFS_BUF;
	logic core_clk = 0, nrst = 0, avs_read = 0, avs_write = 0;
	logic [4:0] avs_address = 0;
	logic [31:0] avs_writedata = 0, avs_readdata, q;
	logic avs_waitrequest, irq, scl_out, sda_out, scl_oe_n, sda_oe_n, p_scl, p_sda;
	logic hold_scl = 0, hold_sda = 0, scl_q = 1, sda_q = 1;
	logic [7:0] b;
	bit bits[$];
	int n_mismatch = 0, checks_done = 0;
	wire logic scl = scl_oe_n & p_scl;  // pulled-up wired and
	wire logic sda = sda_oe_n & p_sda;
	always #20 core_clk = ~core_clk;
	iicm_master u_iicm_master (.core_clk(core_clk), .nrst(nrst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
		.scl_in(scl), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n));
	iicm_bus_peer u_iicm_bus_peer (.core_clk(core_clk), .scl(scl), .sda(sda),
		.hold_scl(hold_scl), .hold_sda(hold_sda), .scl_oe_n(p_scl), .sda_oe_n(p_sda));
	// reference model: data at each clock rise, emptied by a start
	always @(posedge core_clk) begin
		scl_q <= scl;
		sda_q <= sda;
		if (scl && sda_q && !sda) bits.delete();
		else if (scl && !scl_q) bits.push_back(sda);
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// one avalon access, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		avs_read <= !wr;
		avs_write <= wr;
		avs_address <= a;
		avs_writedata <= d;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 0;
		avs_write <= 0;
		chk("answer", 2, n);
	endtask : bus
	task automatic rd(input logic [4:0] a, input logic [31:0] e, input string nm);
		bus(0, a, 0);
		chk(nm, e, q & 32'h0000000F);
	endtask : rd
	task automatic wirq();
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 4000) begin
			@(posedge core_clk);
			n++;
		end
		chk("irq", 1, irq);
	endtask : wirq
	function automatic logic [7:0] got();
		logic [7:0] v;
		v = 0;
		for (int i = 0; i < 8 && i < bits.size(); i++) v[7-i] = bits[i];
		return v;
	endfunction : got
	// start, then one random byte checked on the wire
	task automatic send();
		bus(1, r_ctl, 1);
		wirq();
		rd(r_irq, 1, "start done");
		b = 8'($urandom);
		bus(1, r_buf, {24'h0, b});
		wirq();
		rd(r_irq, 1, "byte done");
		chk("wire byte", b, got());
	endtask : send
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : finish_test
	initial begin
		#4000000;
		n_mismatch++;
		finish_test();
	end
	initial begin
		void'($urandom(48593));
		repeat (10) @(posedge core_clk);
		nrst <= 1;
		rd(iicm_pkg::OFS_BAUD, 32'h09, "baud reset");
		rd(r_sta, 32'h08, "free at reset");
		bus(1, iicm_pkg::OFS_MASK, 32'h03);
		bus(1, iicm_pkg::OFS_BAUD, 32'(2 + $urandom % 6));
		// start while another party holds the clock low
		hold_scl <= 1;
		repeat (4) @(posedge core_clk);
		bus(1, r_ctl, 1);
		wirq();
		rd(r_irq, 2, "start collision");
		rd(r_ctl, 0, "enables cleared");
		@(posedge core_clk);
		chk("irq cleared", 0, irq);
		hold_scl <= 0;
		send();
		rd(r_sta, 32'h02, "busy bus");
		// another party pulls data low under a released one
		hold_sda <= 1;
		bus(1, r_buf, 32'hFF);
		wirq();
		rd(r_irq, 2, "data collision");
		rd(r_sta, 32'h02, "buffer flag");
		chk("released", 3, {scl_oe_n, sda_oe_n});
		repeat (4) @(posedge core_clk);
		hold_sda <= 0;
		wirq();
		rd(r_irq, 1, "stop seen");
		rd(r_sta, 32'h0C, "bus free");
		send();
		bus(1, r_ctl, 2);
		wirq();
		rd(r_irq, 1, "rstart done");
		bus(1, r_ctl, 32'h04);
		wirq();
		rd(r_irq, 1, "stop done");
		finish_test();
	end
endmodule : iicm_master_bench
`default_nettype wire

//--- testbench/iicm_master_monitor.sv
// port checker for the i2c collision block
`timescale 1ns/1ps
`default_nettype none
module iicm_master_monitor (
	input wire logic                         core_clk,
	input wire logic                         nrst,
	input wire logic [iicm_pkg::ADDR_W-1:0]  avs_address,
	input wire logic                         avs_read,
	input wire logic                         avs_write,
	input wire logic [iicm_pkg::DATA_W-1:0]  avs_writedata,
	input wire logic [iicm_pkg::DATA_W-1:0]  avs_readdata,
	input wire logic                         avs_waitrequest,
	input wire logic                         irq,
	input wire logic                         scl_in,
	input wire logic                         scl_out,
	input wire logic                         scl_oe_n,
	input wire logic                         sda_in,
	input wire logic                         sda_out,
	input wire logic                         sda_oe_n
);
	// start request taken while we release both lines
	wire logic go = avs_write && !avs_waitrequest && avs_address == iicm_pkg::OFS_CTRL
		&& avs_writedata[iicm_pkg::CTL_START] && scl_oe_n && sda_oe_n;
	// accesses allowed to lower the interrupt
	wire logic clr = (avs_read && avs_address == iicm_pkg::OFS_IRQ)
		|| (avs_write && avs_address == iicm_pkg::OFS_MASK);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	property p_wait_first; $rose(avs_read || avs_write) |-> avs_waitrequest; endproperty
	property p_one_wait; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
	property p_pins_low; !scl_out && !sda_out; endproperty
	property p_start_low; go && !scl_in && !$past(scl_in) && !$past(scl_in, 2)
		&& !$past(scl_in, 3) |=> (sda_oe_n && scl_oe_n) [*8]; endproperty
	property p_start_sda; go && scl_in && sda_in && $past(scl_in, 3) && $past(sda_in, 3)
		|-> ##[1:300] !sda_oe_n; endproperty
	property p_start_scl; $fell(sda_oe_n) && scl_oe_n |-> ##[1:300] !scl_oe_n; endproperty
	property p_irq_fall; $fell(irq) |-> $past(clr) || $past(clr, 2); endproperty
	property p_rdata_hold; $changed(avs_readdata) |-> $past(avs_read); endproperty
	a_wait_first: assert property (p_wait_first) else $error("no wait cycle");
	a_one_wait: assert property (p_one_wait) else $error("wait longer than one cycle");
	a_pins_low: assert property (p_pins_low) else $error("pin drive value not low");
	a_start_low: assert property (p_start_low) else $error("start on low clock drove");
	a_start_sda: assert property (p_start_sda) else $error("start data never low");
	a_start_scl: assert property (p_start_scl) else $error("start clock never low");
	a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped alone");
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
	c_start: cover property ($fell(scl_oe_n));
	c_irq: cover property ($rose(irq));
	c_go: cover property (go);
endmodule : iicm_master_monitor
bind iicm_master iicm_master_monitor u_iicm_master_monitor (.core_clk(core_clk), .nrst(nrst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .irq(irq), .scl_in(scl_in), .scl_out(scl_out),
	.scl_oe_n(scl_oe_n), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n));
`default_nettype wire
